// ### rtl/pfs_pkg.sv
// Purpose: Shared constants and types of the protection fault supervisor
// Assumes: 10 MHz clock, timers counting a 1 us reference tick
// Notes: Filter times are given in microseconds and turned into ticks here
package pfs_pkg;

  // ***************************************************
  // Clock and reference tick
  // ***************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_DIV = TICK_NS / CLK_PERIOD_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

  // ***************************************************
  // Filter and timer times, microseconds
  // ***************************************************
  localparam int LHI_FILT_LF_US = 50;
  localparam int LHI_FILT_HF_US = 35;
  localparam int LLO_FILT_US = 350;
  localparam int OVP_FILT_LF_US = 55;
  localparam int OVP_FILT_HF_US = 35;
  localparam int SUPPLY_FILT_US = 10;
  // Least times round up to whole ticks
  localparam logic [31:0] LHI_LF_TK = 32'((LHI_FILT_LF_US * 1000 + TICK_NS - 1) / TICK_NS);
  localparam logic [31:0] LHI_HF_TK = 32'((LHI_FILT_HF_US * 1000 + TICK_NS - 1) / TICK_NS);
  localparam logic [31:0] LLO_TK = 32'((LLO_FILT_US * 1000 + TICK_NS - 1) / TICK_NS);
  localparam logic [31:0] OVP_LF_TK = 32'((OVP_FILT_LF_US * 1000 + TICK_NS - 1) / TICK_NS);
  localparam logic [31:0] OVP_HF_TK = 32'((OVP_FILT_HF_US * 1000 + TICK_NS - 1) / TICK_NS);
  localparam logic [31:0] SUPPLY_TK = 32'((SUPPLY_FILT_US * 1000 + TICK_NS - 1) / TICK_NS);
  localparam logic [2:0] WSHORT_CYCLES = 3'h4;

  // ***************************************************
  // Timer slots
  // ***************************************************
  localparam int TM_TRAN = 0;
  localparam int TM_FAULT = 1;
  localparam int TM_LHI = 2;
  localparam int TM_LLO = 3;
  localparam int TM_OVP = 4;
  localparam int TM_UVLO = 5;
  localparam int TM_OVLO = 6;
  localparam int TM_OFFM = 7;
  localparam int TM_AREC = 8;
  localparam int TM_SS = 9;
  localparam int NUM_TM = 10;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int CTRL_AUTOREC = 0;
  localparam int CTRL_HIGH_FREQ = 1;
  localparam int CTRL_LONG_OFF = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Supervisor states, one-hot
  typedef enum logic [7:0] {
    ST_OFF = 8'h01,
    ST_SOFT = 8'h02,
    ST_RUN = 8'h04,
    ST_PROT = 8'h08,
    ST_LATCH = 8'h10,
    ST_STOP = 8'h20,
    ST_TSD = 8'h40,
    ST_OFFM = 8'h80
  } pfs_state_e;

endpackage

// ### rtl/pfs_timer.sv
// Purpose: Tick-driven qualification timer
// Assumes: tick is a one-cycle enable pulse
// Notes: Count clears whenever run drops, so a short condition never expires
`timescale 1ns/1ps
`default_nettype none
module pfs_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic [31:0] limit,
  output logic expired
);

  logic [31:0] count_q;
  logic [31:0] count_d;
  logic expired_q;
  logic expired_d;

  // Count ticks while run holds; saturate at the limit
  always_comb
  begin
    count_d = count_q;
    expired_d = expired_q;
    if (!run)
    begin
      count_d = 32'h0;
      expired_d = 1'b0;
    end
    else if (tick && !expired_q)
    begin
      count_d = count_q + 32'h1;
      expired_d = (count_d >= limit);
    end
  end

  // State registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= 32'h0;
      expired_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q;

  // Expiry never before the limit of ticks
  a_timer_early: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(expired_q) |-> (count_q >= limit))
    else $error("timer expired before its limit");

  // A dropped condition clears the timer
  a_timer_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !run |=> (!expired_q && count_q == 32'h0))
    else $error("timer not cleared when condition left");

endmodule
`default_nettype wire

// ### rtl/pfs_supervisor.sv
// Purpose: Fault supervisor deciding when gate pulses may run
// Assumes: Comparator flags are asynchronous levels, cycle_end toggles high
//          once per switching cycle
// Notes: Build option bits sit in a control register over AXI4-Lite
// Operation
// - Peak-power level runs transient timer to protection
// - Protection latches or autorecovers per option
// - Current limit also runs overload fault timer
// - Brown-out or supply reset releases every latch
// - Latch pin outside window latches off
// - Latch pin spikes below 50/35 us (upper) or 350 us (lower) ignored
// - Latch pin latch cleared only by brown-out/reset
// - Latch pin ignored before ready to start
// - Start switching only without upper latch crossing; checked only from ST_OFF, not on restarts from ST_STOP, ST_TSD, ST_OFFM
// - Lower latch threshold checked after soft-start
// - Thermistor bias boosted during soft-start
// - Over-temperature stops switching at once
// - Over-temperature also stops high-voltage start source
// - Over-temperature restart needs flag clear, line, supply
// - Long low feedback enters off mode
// - External fault filtered 55/35 us, not autorecovered
// - Fault timer clears when current limit leaves
// - Four consecutive winding-short cycles enter protection
// - Maximum on-time termination also runs fault timer
// - Autorecovery restarts after its delay
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor #(
  parameter int TRAN_US = 6000000,
  parameter int FAULT_US = 100000,
  parameter int OFF_SHORT_US = 150000,
  parameter int OFF_LONG_US = 500000,
  parameter int AREC_US = 1000000,
  parameter int SSTART_US = 10000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic current_limit_cmp,
  input wire logic peak_power_cmp,
  input wire logic max_on_time_hit,
  input wire logic winding_short_cmp,
  input wire logic cycle_end,
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic supply_turn_on_level,
  input wire logic supply_reset_level,
  input wire logic line_brown_out,
  input wire logic line_sense_input,
  input wire logic over_temperature_flag,
  input wire logic feedback_below_off,
  input wire logic feedback_above_on,
  input wire logic latch_high_cmp,
  input wire logic latch_low_cmp,
  input wire logic ext_fault_cmp,
  output logic gate_enable,
  output logic hv_source_enable,
  output logic boosted_thermistor_current,
  output logic internal_supply_enable,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  localparam int NIN = 17;
  logic [NIN-1:0] pins;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic cyc3_q;
  logic ilim_s, peak_s, maxon_s, wsh_s, cyc_s, uvlo_s, ovlo_s, von_s;
  logic vrst_s, brown_s, line_s, tsd_s, fboff_s, fbon_s, lhi_s, llo_s;
  logic ovp_s;

  assign pins = {current_limit_cmp, peak_power_cmp, max_on_time_hit,
                 winding_short_cmp, cycle_end, supply_low, supply_high,
                 supply_turn_on_level, supply_reset_level, line_brown_out,
                 line_sense_input, over_temperature_flag, feedback_below_off,
                 feedback_above_on, latch_high_cmp, latch_low_cmp,
                 ext_fault_cmp};
  assign {ilim_s, peak_s, maxon_s, wsh_s, cyc_s, uvlo_s, ovlo_s, von_s,
          vrst_s, brown_s, line_s, tsd_s, fboff_s, fbon_s, lhi_s, llo_s,
          ovp_s} = sync2_q;

  // Two stages; third stage only for the cycle edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      cyc3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      cyc3_q <= sync2_q[12];
    end
  end

  // ***************************************************
  // Reference tick divider
  // ***************************************************
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic tick;

  // One tick per microsecond for every timer
  always_comb
  begin
    div_d = (div_q == pfs_pkg::TICK_LAST) ? 4'h0 : div_q + 4'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= 4'h0;
    else
      div_q <= div_d;
  end

  assign tick = (div_q == pfs_pkg::TICK_LAST);

  // ***************************************************
  // Register file
  // ***************************************************
  logic [2:0] ctrl_q, ctrl_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  pfs_pkg::pfs_state_e state_q, state_d;
  logic gate_q, hv_q, boost_q, vint_q;
  logic autorec, high_freq, long_off;

  assign autorec = ctrl_q[pfs_pkg::CTRL_AUTOREC];
  assign high_freq = ctrl_q[pfs_pkg::CTRL_HIGH_FREQ];
  assign long_off = ctrl_q[pfs_pkg::CTRL_LONG_OFF];

  // Address and data taken in either order; write once both are held
  always_comb
  begin
    ctrl_d = ctrl_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = pfs_pkg::RESP_OKAY;
      if (awaddr_q[11:2] == pfs_pkg::REG_CTRL[11:2])
      begin
        if (wstrb_q[0])
          ctrl_d = wdata_q[2:0];
      end
      else if (awaddr_q[11:2] != pfs_pkg::REG_STATUS[11:2])
        bresp_d = pfs_pkg::RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = pfs_pkg::RESP_OKAY;
      if (s_axi_araddr[11:2] == pfs_pkg::REG_CTRL[11:2])
        rdata_d = {29'h0, ctrl_q};
      else if (s_axi_araddr[11:2] == pfs_pkg::REG_STATUS[11:2])
        rdata_d = {20'h0, vint_q, boost_q, hv_q, gate_q, state_q};
      else
      begin
        rdata_d = 32'h0;
        rresp_d = pfs_pkg::RESP_SLVERR;
      end
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= pfs_pkg::CTRL_RESET;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ***************************************************
  // Fault timers
  // ***************************************************
  logic active, in_run;
  logic [pfs_pkg::NUM_TM-1:0] run, exp;
  logic [31:0] lim [pfs_pkg::NUM_TM];

  assign active = (state_q == pfs_pkg::ST_SOFT) || (state_q == pfs_pkg::ST_RUN);
  assign in_run = (state_q == pfs_pkg::ST_RUN);

  // Run conditions; latch pin only looked at once ready to start
  always_comb
  begin
    run = '0;
    run[pfs_pkg::TM_TRAN] = active && peak_s;
    run[pfs_pkg::TM_FAULT] = active && (ilim_s || maxon_s);
    run[pfs_pkg::TM_LHI] = active && lhi_s;
    run[pfs_pkg::TM_LLO] = in_run && llo_s;
    run[pfs_pkg::TM_OVP] = active && ovp_s;
    run[pfs_pkg::TM_UVLO] = active && uvlo_s;
    run[pfs_pkg::TM_OVLO] = active && ovlo_s;
    run[pfs_pkg::TM_OFFM] = active && fboff_s;
    run[pfs_pkg::TM_AREC] = (state_q == pfs_pkg::ST_PROT) && autorec;
    run[pfs_pkg::TM_SS] = (state_q == pfs_pkg::ST_SOFT);
  end

  // Limits picked by option bits; upper latch and external fault filters per frequency variant
  always_comb
  begin
    lim[pfs_pkg::TM_TRAN] = 32'(TRAN_US);
    lim[pfs_pkg::TM_FAULT] = 32'(FAULT_US);
    lim[pfs_pkg::TM_LHI] = high_freq ? pfs_pkg::LHI_HF_TK : pfs_pkg::LHI_LF_TK;
    lim[pfs_pkg::TM_LLO] = pfs_pkg::LLO_TK;
    lim[pfs_pkg::TM_OVP] = high_freq ? pfs_pkg::OVP_HF_TK : pfs_pkg::OVP_LF_TK;
    lim[pfs_pkg::TM_UVLO] = pfs_pkg::SUPPLY_TK;
    lim[pfs_pkg::TM_OVLO] = pfs_pkg::SUPPLY_TK;
    lim[pfs_pkg::TM_OFFM] = long_off ? 32'(OFF_LONG_US) : 32'(OFF_SHORT_US);
    lim[pfs_pkg::TM_AREC] = 32'(AREC_US);
    lim[pfs_pkg::TM_SS] = 32'(SSTART_US);
  end

  genvar gi;
  generate
    for (gi = 0; gi < pfs_pkg::NUM_TM; gi++)
    begin : g_tm
      pfs_timer u_tm (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .run(run[gi]),
        .limit(lim[gi]),
        .expired(exp[gi])
      );
    end
  endgenerate

  // ***************************************************
  // Winding short cycle counter
  // ***************************************************
  logic [2:0] wsh_cnt_q, wsh_cnt_d;
  logic cyc_edge, wsh_trip;

  assign cyc_edge = cyc_s && !cyc3_q;
  assign wsh_trip = active && cyc_edge && wsh_s &&
                    (wsh_cnt_q == pfs_pkg::WSHORT_CYCLES - 3'h1);

  // Any clean cycle breaks the run of consecutive trips
  always_comb
  begin
    wsh_cnt_d = wsh_cnt_q;
    if (!active || wsh_trip)
      wsh_cnt_d = 3'h0;
    else if (cyc_edge)
      wsh_cnt_d = wsh_s ? wsh_cnt_q + 3'h1 : 3'h0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wsh_cnt_q <= 3'h0;
    else
      wsh_cnt_q <= wsh_cnt_d;
  end

  // ***************************************************
  // Supervisor state machine
  // ***************************************************
  logic latch_ev, prot_ev;

  assign latch_ev = exp[pfs_pkg::TM_LHI] || exp[pfs_pkg::TM_LLO] ||
                    exp[pfs_pkg::TM_OVP] || exp[pfs_pkg::TM_OVLO];
  assign prot_ev = exp[pfs_pkg::TM_TRAN] || exp[pfs_pkg::TM_FAULT] ||
                   exp[pfs_pkg::TM_UVLO] || wsh_trip;

  // Releases ordered by strength; supply reset beats all
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pfs_pkg::ST_OFF:
        if (von_s && line_s && !tsd_s && !lhi_s)
          state_d = pfs_pkg::ST_SOFT;
      pfs_pkg::ST_SOFT, pfs_pkg::ST_RUN:
        if (tsd_s)
          state_d = pfs_pkg::ST_TSD;
        else if (latch_ev)
          state_d = pfs_pkg::ST_LATCH;
        else if (prot_ev)
          state_d = pfs_pkg::ST_PROT;
        else if (exp[pfs_pkg::TM_OFFM])
          state_d = pfs_pkg::ST_OFFM;
        else if (state_q == pfs_pkg::ST_SOFT && exp[pfs_pkg::TM_SS])
          state_d = pfs_pkg::ST_RUN;
      pfs_pkg::ST_PROT:
        if (autorec && exp[pfs_pkg::TM_AREC])
          state_d = pfs_pkg::ST_OFF;
      pfs_pkg::ST_STOP:
        if (line_s && von_s)
          state_d = pfs_pkg::ST_SOFT;
      pfs_pkg::ST_TSD:
        if (!tsd_s && line_s && von_s)
          state_d = pfs_pkg::ST_SOFT;
      pfs_pkg::ST_OFFM:
        if (line_s && von_s && fbon_s)
          state_d = pfs_pkg::ST_SOFT;
      default:
        state_d = state_q;
    endcase
    if (vrst_s)
      state_d = pfs_pkg::ST_OFF;
    else if (brown_s && state_q != pfs_pkg::ST_TSD)
      state_d = pfs_pkg::ST_STOP;
  end

  // Outputs follow the next state so they match state_q
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= pfs_pkg::ST_OFF;
      gate_q <= 1'b0;
      hv_q <= 1'b1;
      boost_q <= 1'b0;
      vint_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      gate_q <= (state_d == pfs_pkg::ST_SOFT) || (state_d == pfs_pkg::ST_RUN);
      hv_q <= (state_d != pfs_pkg::ST_TSD);
      boost_q <= (state_d == pfs_pkg::ST_SOFT);
      vint_q <= (state_d != pfs_pkg::ST_OFFM);
    end
  end

  assign gate_enable = gate_q;
  assign hv_source_enable = hv_q;
  assign boosted_thermistor_current = boost_q;
  assign internal_supply_enable = vint_q;

  // ***************************************************
  // Checks
  // ***************************************************
  a_gate_off_idle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(state_q inside {pfs_pkg::ST_SOFT, pfs_pkg::ST_RUN}) |-> !gate_q)
    else $error("gate enabled outside soft-start or run");

  a_tsd_stop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (active && tsd_s && !vrst_s && !brown_s)
      |=> (!gate_q && state_q == pfs_pkg::ST_TSD))
    else $error("over-temperature did not stop gate");

  a_tsd_hv_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == pfs_pkg::ST_TSD) |-> (!hv_q && !gate_q))
    else $error("start-up source on during over-temperature");

  a_boost_soft: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(boost_q) |-> (state_q != pfs_pkg::ST_SOFT && $past(state_q) == pfs_pkg::ST_SOFT))
    else $error("bias boost ended outside soft-start exit");

  a_wshort_four: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wsh_trip && !tsd_s && !latch_ev && !vrst_s && !brown_s)
      |=> (state_q == pfs_pkg::ST_PROT))
    else $error("fourth winding-short cycle missed");

  a_latch_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == pfs_pkg::ST_LATCH && !vrst_s && !brown_s)
      |=> (state_q == pfs_pkg::ST_LATCH))
    else $error("latch released without brown-out or reset");

  a_prot_latched: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == pfs_pkg::ST_PROT && !autorec && !vrst_s && !brown_s)
      |=> (state_q == pfs_pkg::ST_PROT))
    else $error("latched protection released");

  a_start_block: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == pfs_pkg::ST_OFF && lhi_s) |=> (state_q != pfs_pkg::ST_SOFT))
    else $error("start with upper latch crossed");

  a_off_ignore: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == pfs_pkg::ST_OFF) |=> (state_q != pfs_pkg::ST_LATCH))
    else $error("latch pin acted before start");

  a_offm_supply: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (state_q == pfs_pkg::ST_OFFM) |-> (!vint_q && !gate_q))
    else $error("internal supply on in off mode");

endmodule
`default_nettype wire

// ### verif/pfs_gate_model.sv
// Purpose: Gate driver side model giving switching cycle ends
// Assumes: One switching cycle every 20 clocks
// Notes: Quiet while gating is off, as a stopped driver would be
`timescale 1ns/1ps
`default_nettype none
module pfs_gate_model (
  input wire logic aclk,
  input wire logic gate_enable,
  output logic cycle_end
);
  logic [4:0] cnt_q;
  // Cycle counter, held at zero while the gate is off
  always_ff @(posedge aclk)
  begin
    if (gate_enable !== 1'b1)
      cnt_q <= 5'h00;
    else
      cnt_q <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
  end
  // Second half of each cycle marks its end
  assign cycle_end = (gate_enable === 1'b1) && (cnt_q >= 5'h0A);
endmodule
`default_nettype wire

// ### verif/pfs_supervisor_bench.sv
// Purpose: Self-checking bench of the fault supervisor
// Assumes: Shortened timers, one microsecond is ten clocks
// Notes: Waits exceed each filter by a few ticks of margin
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor_bench;
  // ***************************************************
  // Stimulus, observation and helpers
  // ***************************************************
  logic aclk = 1'b0, aresetn = 1'b0, current_limit_cmp = 1'b0;
  logic peak_power_cmp = 1'b0, max_on_time_hit = 1'b0, cycle_end;
  logic winding_short_cmp = 1'b0, supply_low = 1'b0, supply_high = 1'b0;
  logic supply_turn_on_level = 1'b0, supply_reset_level = 1'b0;
  logic line_brown_out = 1'b0, line_sense_input = 1'b0;
  logic over_temperature_flag = 1'b0, feedback_below_off = 1'b0;
  logic feedback_above_on = 1'b1, latch_high_cmp = 1'b0;
  logic latch_low_cmp = 1'b0, ext_fault_cmp = 1'b0, gate_enable;
  logic hv_source_enable, boosted_thermistor_current;
  logic internal_supply_enable, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  int mismatches = 0, n_compared = 0, cycles = 0;

  pfs_supervisor #(.TRAN_US(50), .FAULT_US(20), .OFF_SHORT_US(30),
    .OFF_LONG_US(60), .AREC_US(40), .SSTART_US(20)) DUT (.*);
  pfs_gate_model partner (.*);

  // Free running clock; a hang is cut short by the cycle ceiling
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic us(input int n);
    repeat (n * 10) @(posedge aclk);
  endtask

  // Write with both channels offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_reset;
    chk("outs", 32'({internal_supply_enable, boosted_thermistor_current,
      hv_source_enable, gate_enable}), 32'h0000000A);
    rdr(pfs_pkg::REG_STATUS);
    chk("status", rd, {20'h0, 4'hA, pfs_pkg::ST_OFF});
    rdr(pfs_pkg::REG_CTRL);
    chk("ctrl", rd, 32'h0);
    rdr(12'h008);
    chk("rresp", 32'(resp), 32'(pfs_pkg::RESP_SLVERR));
    wr(12'h00C, 32'h1);
    chk("bresp", 32'(resp), 32'(pfs_pkg::RESP_SLVERR));
    $display("test reset done");
  endtask

  task automatic t_start;
    latch_high_cmp <= 1'b1;
    supply_turn_on_level <= 1'b1;
    line_sense_input <= 1'b1;
    us(5);
    chk("held", 32'({boosted_thermistor_current, gate_enable}), 32'h0);
    latch_high_cmp <= 1'b0;
    us(2);
    rdr(pfs_pkg::REG_STATUS);
    chk("soft", 32'({boosted_thermistor_current, rd[7:0]}),
      32'({1'b1, pfs_pkg::ST_SOFT}));
    us(25);
    chk("run", 32'({boosted_thermistor_current, gate_enable}), 32'h1);
    $display("test start done");
  endtask

  task automatic t_fault(input logic ar);
    wr(pfs_pkg::REG_CTRL, 32'(ar));
    current_limit_cmp <= 1'b1;
    us(10);
    current_limit_cmp <= 1'b0;
    us(15);
    chk("brief", 32'(gate_enable), 32'h1);
    current_limit_cmp <= 1'b1;
    us(25);
    chk("fault", 32'(gate_enable), 32'h0);
    current_limit_cmp <= 1'b0;
    us(50);
    rdr(pfs_pkg::REG_STATUS);
    chk("after", 32'(rd[7:0]),
      32'(ar ? pfs_pkg::ST_SOFT : pfs_pkg::ST_PROT));
    if (!ar)
    begin
      line_brown_out <= 1'b1;
      us(5);
      line_brown_out <= 1'b0;
      us(15);
    end
    us(20);
    chk("back", 32'(gate_enable), 32'h1);
    $display("test fault done");
  endtask

  task automatic t_latch;
    latch_high_cmp <= 1'b1;
    us(30);
    latch_high_cmp <= 1'b0;
    us(2);
    chk("spike", 32'(gate_enable), 32'h1);
    latch_high_cmp <= 1'b1;
    us(55);
    chk("latch", 32'(gate_enable), 32'h0);
    latch_high_cmp <= 1'b0;
    us(60);
    chk("kept", 32'(gate_enable), 32'h0);
    supply_reset_level <= 1'b1;
    us(2);
    supply_reset_level <= 1'b0;
    us(30);
    chk("freed", 32'(gate_enable), 32'h1);
    $display("test latch done");
  endtask

  task automatic t_tsd;
    over_temperature_flag <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("tsd", 32'({internal_supply_enable, hv_source_enable,
      gate_enable}), 32'h4);
    over_temperature_flag <= 1'b0;
    us(30);
    chk("cool", 32'(gate_enable), 32'h1);
    $display("test thermal done");
  endtask

  task automatic t_more;
    winding_short_cmp <= 1'b1;
    us(12);
    chk("short", 32'(gate_enable), 32'h0);
    winding_short_cmp <= 1'b0;
    us(70);
    chk("retry", 32'(gate_enable), 32'h1);
    feedback_above_on <= 1'b0;
    feedback_below_off <= 1'b1;
    us(35);
    chk("offm", 32'(internal_supply_enable), 32'h0);
    feedback_below_off <= 1'b0;
    feedback_above_on <= 1'b1;
    us(30);
    chk("wake", 32'(gate_enable), 32'h1);
    $display("test short and off done");
  endtask

  // Peak power runs the long timer; external fault ignores autorecovery
  task automatic t_peak;
    peak_power_cmp <= 1'b1;
    us(40);
    chk("tran", 32'(gate_enable), 32'h1);
    us(15);
    chk("peak", 32'(gate_enable), 32'h0);
    peak_power_cmp <= 1'b0;
    us(70);
    ext_fault_cmp <= 1'b1;
    us(60);
    chk("ext", 32'(gate_enable), 32'h0);
    ext_fault_cmp <= 1'b0;
    us(60);
    chk("ext_kept", 32'(gate_enable), 32'h0);
    line_brown_out <= 1'b1;
    us(5);
    line_brown_out <= 1'b0;
    us(30);
    chk("ext_freed", 32'(gate_enable), 32'h1);
    $display("test peak and external done");
  endtask

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_start();
    t_fault(1'b0);
    t_fault(1'b1);
    t_latch();
    t_tsd();
    t_more();
    t_peak();
    results();
  end
endmodule
`default_nettype wire
